// ==== src/hfq_pkg.sv ====
// package for the host frame queue control block: register map, sizes, timing
// assumes a single 100 MHz clock and one aligned 32-bit word per register
package hfq_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS = 10;
	// time the queue memory needs to give back a released rx frame
	localparam int unsigned RELEASE_NS = 20;
	localparam int unsigned RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] RELEASE_CYC_C = 4'(RELEASE_CYC);

	// ==========================================================
	// queue sizes
	localparam int unsigned CNT_W = 13;
	localparam logic [12:0] QUEUE_BYTES = 13'h1000;
	localparam logic [12:0] STATUS_WORD_BYTES = 13'h004;
	localparam int unsigned LEN_FIFO_DEPTH = 8;

	// ==========================================================
	// register indices, byte address is four times the index
	localparam logic [3:0] TX_ENQUEUE_COMMAND_IDX = 4'h0;
	localparam logic [3:0] RX_RELEASE_COMMAND_IDX = 4'h2;
	localparam logic [3:0] TX_FREE_SPACE_IDX = 4'h8;
	localparam logic [3:0] RX_PENDING_BYTES_IDX = 4'ha;
	localparam logic [3:0] INTERRUPT_ENABLE_REG_IDX = 4'hc;

	// ==========================================================
	// field positions and reset values
	localparam int unsigned CMD_BIT = 0;
	localparam int unsigned RX_IRQ_EN_BIT = 13;
	localparam logic CMD_RST = 1'b0;
	localparam logic IRQ_EN_RST = 1'b0;
	localparam logic HRESP_OKAY = 1'b0;

	function automatic logic hfq_reg_known(input logic [3:0] idx);
		return (idx == TX_ENQUEUE_COMMAND_IDX) || (idx == RX_RELEASE_COMMAND_IDX) ||
			(idx == TX_FREE_SPACE_IDX) || (idx == RX_PENDING_BYTES_IDX) ||
			(idx == INTERRUPT_ENABLE_REG_IDX);
	endfunction : hfq_reg_known

endpackage : hfq_pkg

// ==== src/hfq_reg_if.sv ====
// interface between the bus slave and the register file of the queue block
// assumes both ends run on the same clock; strobes are one cycle wide
`timescale 1ns/1ps
`default_nettype none
interface hfq_reg_if;
	logic wr;
	logic [3:0] idx;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport bus (output wr, output idx, output wdata, input rdata);
	modport regs (input wr, input idx, input wdata, output rdata);
endinterface : hfq_reg_if
`default_nettype wire

// ==== src/hfq_ahb_slave.sv ====
// ahb-lite slave front end: zero wait writes, one wait state on reads
// assumes it is the only slave, so hready is its own hreadyout
`timescale 1ns/1ps
`default_nettype none
module hfq_ahb_slave
	import hfq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	hfq_reg_if.bus regs
);
	import hfq_pkg::*;

	typedef struct packed {
		logic ph_valid;
		logic ph_write;
		logic ph_map;
		logic [3:0] ph_idx;
		logic rd_wait;
		logic [31:0] rdata;
	} hfq_ahb_st_t;

	hfq_ahb_st_t st_q, st_d;
	logic rd_first;

	// ==========================================================
	// data phase and address capture
	always_comb begin
		st_d = st_q;
		// the wait state lets the read value be registered before it is driven on hrdata
		rd_first = st_q.ph_valid && !st_q.ph_write && !st_q.rd_wait;
		hreadyout = !rd_first;
		regs.wr = st_q.ph_valid && st_q.ph_write && st_q.ph_map;
		regs.idx = st_q.ph_idx;
		regs.wdata = hwdata[15:0];
		if (rd_first) begin
			st_d.rd_wait = 1'b1;
			st_d.rdata = st_q.ph_map ? {16'h0000, regs.rdata} : 32'h0000_0000;
		end
		if (hready) begin
			st_d.rd_wait = 1'b0;
			st_d.ph_valid = hsel && htrans[1];
			st_d.ph_write = hwrite;
			st_d.ph_idx = haddr[5:2];
			st_d.ph_map = (haddr[31:6] == 26'h0) && (haddr[1:0] == 2'h0) &&
				hfq_reg_known(haddr[5:2]);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign hresp = HRESP_OKAY;
	assign hrdata = st_q.rdata;

endmodule : hfq_ahb_slave
`default_nettype wire

// ==== src/hfq_len_fifo.sv ====
// small fifo of byte counts, one entry per rx frame held in the queue
// assumes the caller never pushes when full nor pops when empty
`timescale 1ns/1ps
`default_nettype none
module hfq_len_fifo #(
	parameter int unsigned DEPTH = 8,
	parameter int unsigned W = 13
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic [W-1:0] push_len,
	input wire logic pop,
	output logic [W-1:0] head,
	output logic full,
	output logic empty
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] rd;
		logic [AW-1:0] wr;
		logic [AW:0] cnt;
	} hfq_fifo_st_t;

	hfq_fifo_st_t st_q, st_d;

	// ==========================================================
	// pointer and count update
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr] = push_len;
			st_d.wr = st_q.wr + 1'b1;
		end
		if (pop) begin
			st_d.rd = st_q.rd + 1'b1;
		end
		st_d.cnt = st_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign head = st_q.mem[st_q.rd];
	assign full = (st_q.cnt == (AW + 1)'(DEPTH));
	assign empty = (st_q.cnt == '0);

endmodule : hfq_len_fifo
`default_nettype wire

// ==== src/hfq_top.sv ====
// host frame queue control: free tx space, pending rx bytes and the two
// self clearing queue commands, reached over ahb-lite
// assumes the data window and mac engines sit outside on the same clock
//
// Overview of operation
// R1 - tx free space read as 13-bit byte count in low bits
// R2 - tx queue holds 4096 bytes in total
// R3 - tx free count covers payload and per-frame control word
// R4 - host checks free space covers next frame before writing
// R5 - rx pending data read as 13-bit byte count in low bits
// R6 - rx queue holds 4096 bytes in total
// R7 - rx queue space covers payload and per-frame status word
// R8 - rx pending count moves only when a whole packet lands
// R9 - complete rx packet raises interrupt when enable bit 13 set
// R10 - arriving frame without enough rx space is discarded
// R11 - host drains and releases rx frames promptly
// R12 - writing one to tx command bit 0 queues prepared frame
// R13 - tx command bit stays set until the frame is sent
// R14 - host polls tx command bit low before next frame
// R15 - writing one to rx command bit 0 releases current frame
// R16 - rx command bit stays set until memory is released
// R17 - host polls rx command bit low before next frame
// R18 - enqueue resets tx frame pointer to next frame location
// R19 - release resets rx frame pointer to next frame location
// R20 - reserved register bits read zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
module hfq_top
	import hfq_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic tx_wr_valid,
	input wire logic [2:0] tx_wr_bytes,
	output logic tx_start,
	output logic [hfq_pkg::CNT_W-1:0] tx_frame_len,
	input wire logic tx_done,
	output logic tx_ptr_reset,
	input wire logic rx_frame_valid,
	input wire logic [hfq_pkg::CNT_W-1:0] rx_frame_len,
	output logic rx_irq,
	output logic rx_drop,
	output logic rx_ptr_reset
);
	import hfq_pkg::*;

	typedef struct packed {
		logic tx_cmd;
		logic [12:0] tx_free;
		logic [12:0] tx_staged;
		logic [12:0] tx_inflight;
		logic tx_start;
		logic tx_ptr_reset;
		logic [12:0] tx_len;
		logic rx_cmd;
		logic [3:0] rx_wait;
		logic [12:0] rx_pend;
		logic rx_irq;
		logic rx_drop;
		logic rx_ptr_reset;
		logic irq_en;
	} hfq_st_t;

	hfq_st_t st_q, st_d;
	hfq_reg_if regs ();

	logic wr_tx_cmd, wr_rx_cmd, wr_irq_en;
	logic [12:0] tx_bytes, rx_need, rx_room, rx_add, rx_sub;
	logic rx_fits, rx_accept, rx_pop;
	logic [12:0] fifo_head;
	logic fifo_full, fifo_empty;

	// ==========================================================
	// bus slave and rx frame length store
	hfq_ahb_slave u_bus (
		.mclk(mclk),
		.rst_n(rst_n),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.regs(regs.bus)
	);

	hfq_len_fifo #(.DEPTH(LEN_FIFO_DEPTH), .W(CNT_W)) u_len (
		.mclk(mclk),
		.rst_n(rst_n),
		.push(rx_accept),
		.push_len(rx_need),
		.pop(rx_pop),
		.head(fifo_head),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	// ==========================================================
	// register write decode
	always_comb begin
		wr_tx_cmd = regs.wr && (regs.idx == TX_ENQUEUE_COMMAND_IDX) && regs.wdata[CMD_BIT];
		wr_rx_cmd = regs.wr && (regs.idx == RX_RELEASE_COMMAND_IDX) && regs.wdata[CMD_BIT];
		wr_irq_en = regs.wr && (regs.idx == INTERRUPT_ENABLE_REG_IDX);
	end

	// ==========================================================
	// register read mux, reserved bits zero
	always_comb begin
		case (regs.idx)
			TX_ENQUEUE_COMMAND_IDX: regs.rdata = {15'h0000, st_q.tx_cmd}; // [R20]
			RX_RELEASE_COMMAND_IDX: regs.rdata = {15'h0000, st_q.rx_cmd}; // [R20]
			TX_FREE_SPACE_IDX: regs.rdata = {3'h0, st_q.tx_free}; // [R1]
			RX_PENDING_BYTES_IDX: regs.rdata = {3'h0, st_q.rx_pend}; // [R5]
			INTERRUPT_ENABLE_REG_IDX: regs.rdata = {2'h0, st_q.irq_en, 13'h0000};
			default: regs.rdata = 16'h0000;
		endcase
	end

	// ==========================================================
	// rx admission: payload plus status word must fit
	always_comb begin
		rx_need = rx_frame_len + STATUS_WORD_BYTES; // [R7]
		rx_room = QUEUE_BYTES - st_q.rx_pend; // [R6]
		// uses room before a same-cycle release, so it errs on dropping
		rx_fits = (rx_need <= rx_room) && (rx_frame_len <= QUEUE_BYTES - STATUS_WORD_BYTES);
		rx_accept = rx_frame_valid && rx_fits && !fifo_full; // [R10]
		rx_pop = st_q.rx_cmd && (st_q.rx_wait == 4'h1);
		rx_add = rx_accept ? rx_need : 13'h0000;
		rx_sub = rx_pop ? fifo_head : 13'h0000;
		tx_bytes = {10'h000, tx_wr_bytes};
	end

	// ==========================================================
	// next state
	always_comb begin
		st_d = st_q;
		st_d.tx_start = 1'b0;
		st_d.tx_ptr_reset = 1'b0;
		st_d.rx_irq = 1'b0;
		st_d.rx_drop = 1'b0;
		st_d.rx_ptr_reset = 1'b0;
		if (wr_irq_en) begin
			st_d.irq_en = regs.wdata[RX_IRQ_EN_BIT];
		end
		// host data writes eat space; an overrun write is ignored
		if (tx_wr_valid && (tx_bytes <= st_q.tx_free)) begin
			st_d.tx_free = st_q.tx_free - tx_bytes; // [R3]
			st_d.tx_staged = st_q.tx_staged + tx_bytes;
		end
		if (st_q.tx_cmd && tx_done) begin
			st_d.tx_cmd = 1'b0; // [R13]
			st_d.tx_free = st_d.tx_free + st_q.tx_inflight; // [R2]
			st_d.tx_inflight = 13'h0000;
		end else if (wr_tx_cmd && !st_q.tx_cmd) begin
			// one frame in flight; a second enqueue while the bit is set is ignored
			st_d.tx_cmd = 1'b1; // [R12]
			st_d.tx_inflight = st_q.tx_staged;
			st_d.tx_len = st_q.tx_staged;
			// bytes written in this very cycle belong to the next frame
			st_d.tx_staged = st_d.tx_staged - st_q.tx_staged;
			st_d.tx_start = 1'b1;
			st_d.tx_ptr_reset = 1'b1; // [R18]
		end
		if (rx_pop) begin
			st_d.rx_cmd = 1'b0; // [R16]
			st_d.rx_wait = 4'h0;
		end else if (st_q.rx_cmd) begin
			st_d.rx_wait = st_q.rx_wait - 4'h1;
		end else if (wr_rx_cmd && !fifo_empty) begin
			st_d.rx_cmd = 1'b1; // [R15]
			st_d.rx_wait = RELEASE_CYC_C;
			st_d.rx_ptr_reset = 1'b1; // [R19]
		end
		st_d.rx_pend = st_q.rx_pend + rx_add - rx_sub; // [R8]
		st_d.rx_irq = rx_accept && st_q.irq_en; // [R9]
		st_d.rx_drop = rx_frame_valid && !rx_accept; // [R10]
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.tx_free <= QUEUE_BYTES;
			st_q.tx_cmd <= CMD_RST;
			st_q.rx_cmd <= CMD_RST;
			st_q.irq_en <= IRQ_EN_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign tx_start = st_q.tx_start;
	assign tx_frame_len = st_q.tx_len;
	assign tx_ptr_reset = st_q.tx_ptr_reset;
	assign rx_irq = st_q.rx_irq;
	assign rx_drop = st_q.rx_drop;
	assign rx_ptr_reset = st_q.rx_ptr_reset;

	// ==========================================================
	// checks
	localparam int REL_MAX = 6;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	sequence rel_issue_s;
		wr_rx_cmd && !st_q.rx_cmd && !fifo_empty;
	endsequence

	sequence rel_done_s;
		st_q.rx_cmd ##[1:REL_MAX] !st_q.rx_cmd;
	endsequence

	tx_space_sum_a: assert property ( // [R3]
		st_q.tx_free + st_q.tx_staged + st_q.tx_inflight == QUEUE_BYTES)
		else $error("tx space does not add up to the queue size");

	tx_free_read_a: assert property ( // [R1]
		regs.idx == TX_FREE_SPACE_IDX |-> regs.rdata == {3'h0, st_q.tx_free})
		else $error("tx free space read value wrong");

	tx_enqueue_a: assert property ( // [R12]
		wr_tx_cmd && !st_q.tx_cmd && !tx_done |=> st_q.tx_cmd && tx_start && tx_ptr_reset)
		else $error("enqueue did not start the frame");

	tx_cmd_hold_a: assert property ( // [R13]
		st_q.tx_cmd && !tx_done |=> st_q.tx_cmd)
		else $error("tx command cleared before transmit done");

	rx_pend_bound_a: assert property ( // [R6]
		st_q.rx_pend <= QUEUE_BYTES)
		else $error("rx pending exceeds queue size");

	rx_whole_frame_a: assert property ( // [R8]
		!$stable(st_q.rx_pend) |-> $past(rx_accept) || $past(rx_pop))
		else $error("rx pending moved without a frame event");

	rx_irq_gate_a: assert property ( // [R9]
		rx_irq |-> $past(rx_accept) && $past(st_q.irq_en))
		else $error("rx interrupt without enabled arrival");

	rx_drop_full_a: assert property ( // [R10]
		rx_frame_valid && (rx_need > rx_room) |=> rx_drop && !rx_irq)
		else $error("oversize rx frame not dropped");

	rx_release_a: assert property ( // [R15]
		rel_issue_s |=> rx_ptr_reset ##0 rel_done_s)
		else $error("release did not complete in time");

	rx_release_sub_a: assert property ( // [R16]
		$fell(st_q.rx_cmd) |-> st_q.rx_pend == $past(st_q.rx_pend) - $past(fifo_head)
			+ $past(rx_add))
		else $error("release cleared without freeing memory");

	cmd_reserved_a: assert property ( // [R20]
		regs.idx == RX_RELEASE_COMMAND_IDX |-> regs.rdata[15:1] == 15'h0000)
		else $error("reserved command bits not zero");

	tx_free_bound_a: assert property ( // [R2]
		st_q.tx_free <= QUEUE_BYTES)
		else $error("tx free space exceeds queue size");

	tx_write_space_a: assert property ( // [R3]
		tx_wr_valid && (tx_bytes <= st_q.tx_free) && !(st_q.tx_cmd && tx_done)
		|=> st_q.tx_free == $past(st_q.tx_free) - $past(tx_bytes))
		else $error("tx free space did not drop by the bytes written");

	tx_done_clear_a: assert property ( // [R13]
		st_q.tx_cmd && tx_done |=> !st_q.tx_cmd && (st_q.tx_inflight == 13'h0000))
		else $error("tx command not cleared at transmit done");

	tx_refuse_a: assert property ( // [R12]
		wr_tx_cmd && st_q.tx_cmd && !tx_done |=> st_q.tx_cmd && !tx_start)
		else $error("second enqueue was not refused");

	tx_ptr_pair_a: assert property ( // [R18]
		tx_ptr_reset |-> tx_start && (tx_frame_len == st_q.tx_inflight))
		else $error("tx pointer reset without a matching enqueue");

	tx_ptr_pulse_a: assert property ( // [R18]
		tx_ptr_reset |=> !tx_ptr_reset)
		else $error("tx pointer reset longer than one cycle");

	rx_status_word_a: assert property ( // [R7]
		rx_accept |=> st_q.rx_pend == $past(st_q.rx_pend) + $past(rx_frame_len)
			+ STATUS_WORD_BYTES - $past(rx_sub))
		else $error("rx pending did not add payload and status word");

	rx_ptr_issue_a: assert property ( // [R19]
		rx_ptr_reset |-> st_q.rx_cmd && (st_q.rx_wait == RELEASE_CYC_C))
		else $error("rx pointer reset without a taken release");

	rx_cmd_hold_a: assert property ( // [R16]
		st_q.rx_cmd && (st_q.rx_wait != 4'h1) |=> st_q.rx_cmd)
		else $error("rx command cleared before memory released");

endmodule : hfq_top
`default_nettype wire

// ==== testbench/hfq_mac_model.sv ====
// transmitter model: answers every tx_start with a tx_done pulse
// assumes tx_start is a one-cycle pulse on mclk; delay is set by the bench
`timescale 1ns/1ps
`default_nettype none
module hfq_mac_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tx_start,
	input wire logic [7:0] delay,
	output logic tx_done
);
	logic [7:0] cnt_q;
	logic busy_q;
	// ==========================================================
	// one frame at a time, like a real transmitter
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			busy_q <= 1'b0;
			tx_done <= 1'b0;
		end else begin
			tx_done <= 1'b0;
			if (tx_start) begin
				busy_q <= 1'b1;
				cnt_q <= delay;
			end else if (busy_q && cnt_q == 8'h00) begin
				busy_q <= 1'b0;
				tx_done <= 1'b1;
			end else if (busy_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end
endmodule : hfq_mac_model
`default_nettype wire

// ==== testbench/hfq_top_tb.sv ====
// testbench for the queue control block: ahb-lite host tasks plus
// frame stimulus; assumes hfq_pkg and the design files compiled first
`timescale 1ns/1ps
`default_nettype none
module hfq_top_tb;
	import hfq_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, tx_start, tx_done, tx_ptr_reset;
	logic [31:0] hrdata;
	logic [12:0] tx_frame_len;
	logic tx_wr_valid = 1'b0;
	logic [2:0] tx_wr_bytes = 3'h0;
	logic rx_frame_valid = 1'b0;
	logic [12:0] rx_frame_len = 13'h0;
	logic rx_irq, rx_drop, rx_ptr_reset;
	logic [7:0] delay = 8'h1e;
	int fails = 0;
	int checked = 0;
	int n_start = 0, n_tptr = 0, n_irq = 0, n_drop = 0, n_rptr = 0;

	always #5 mclk = ~mclk;

	hfq_top hfq_top_i (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_wr_valid(tx_wr_valid), .tx_wr_bytes(tx_wr_bytes), .tx_start(tx_start),
		.tx_frame_len(tx_frame_len), .tx_done(tx_done), .tx_ptr_reset(tx_ptr_reset),
		.rx_frame_valid(rx_frame_valid), .rx_frame_len(rx_frame_len), .rx_irq(rx_irq),
		.rx_drop(rx_drop), .rx_ptr_reset(rx_ptr_reset));
	hfq_mac_model hfq_mac_model_i (.mclk(mclk), .rst_n(rst_n), .tx_start(tx_start),
		.delay(delay), .tx_done(tx_done));

	// ==========================================================
	// pulse counters, registered pulses are seen at the following edge
	always @(posedge mclk) begin
		n_start += int'(tx_start);
		n_tptr += int'(tx_ptr_reset);
		n_irq += int'(rx_irq);
		n_drop += int'(rx_drop);
		n_rptr += int'(rx_ptr_reset);
	end

	// ==========================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// entered just after a rising edge; ready and read data taken at the edge
	task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {26'h0, idx, 2'b00};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= wd;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
		check({30'h0, hresp, hreadyout}, 32'h1);
	endtask : bus

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, idx, d, x);
	endtask : wr

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
		logic [31:0] x;
		bus(1'b0, idx, 32'h0, x);
		check(x, exp);
	endtask : rd_chk

	// polls a self clearing command bit until it reads zero
	task automatic poll(input logic [3:0] idx);
		logic [31:0] x;
		int n;
		n = 0;
		do begin
			bus(1'b0, idx, 32'h0, x);
			n++;
		end while (x[0] !== 1'b0 && n < 100);
		check(x, 32'h0);
	endtask : poll

	task automatic tx_bytes(input logic [2:0] b);
		@(posedge mclk);
		tx_wr_valid <= 1'b1;
		tx_wr_bytes <= b;
		@(posedge mclk);
		tx_wr_valid <= 1'b0;
	endtask : tx_bytes

	task automatic rx_frame(input logic [12:0] len);
		@(posedge mclk);
		rx_frame_valid <= 1'b1;
		rx_frame_len <= len;
		@(posedge mclk);
		rx_frame_valid <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask : rx_frame

	task automatic complete_run;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		complete_run();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(TX_FREE_SPACE_IDX, {19'h0, QUEUE_BYTES});
		rd_chk(RX_PENDING_BYTES_IDX, 32'h0);
		rd_chk(TX_ENQUEUE_COMMAND_IDX, 32'h0);
		rd_chk(4'h4, 32'h0);
		wr(TX_FREE_SPACE_IDX, 32'hffff_ffff);
		rd_chk(TX_FREE_SPACE_IDX, {19'h0, QUEUE_BYTES});
		wr(RX_RELEASE_COMMAND_IDX, 32'hffff_fffe);
		rd_chk(RX_RELEASE_COMMAND_IDX, 32'h0);
		wr(INTERRUPT_ENABLE_REG_IDX, 32'hffff_ffff);
		rd_chk(INTERRUPT_ENABLE_REG_IDX, 32'h2000);
		// host checks room first, then writes payload and control word
		rd_chk(TX_FREE_SPACE_IDX, {19'h0, QUEUE_BYTES});
		repeat (3) tx_bytes(3'h4);
		rd_chk(TX_FREE_SPACE_IDX, {19'h0, QUEUE_BYTES - 13'h00c});
		wr(TX_ENQUEUE_COMMAND_IDX, 32'h1);
		wr(TX_ENQUEUE_COMMAND_IDX, 32'h1);
		rd_chk(TX_ENQUEUE_COMMAND_IDX, 32'h1);
		check(32'(n_start), 32'h1);
		check(32'(n_tptr), 32'h1);
		check({19'h0, tx_frame_len}, 32'h00c);
		poll(TX_ENQUEUE_COMMAND_IDX);
		rd_chk(TX_FREE_SPACE_IDX, {19'h0, QUEUE_BYTES});
		// rx side with the interrupt enabled, then disabled
		rx_frame(13'd60);
		rd_chk(RX_PENDING_BYTES_IDX, 32'd64);
		check(32'(n_irq), 32'h1);
		wr(INTERRUPT_ENABLE_REG_IDX, 32'h0);
		rx_frame(13'd100);
		check(32'(n_irq), 32'h1);
		rx_frame(QUEUE_BYTES);
		check(32'(n_drop), 32'h1);
		rd_chk(RX_PENDING_BYTES_IDX, 32'd168);
		// host drains promptly, one frame per release
		wr(RX_RELEASE_COMMAND_IDX, 32'h1);
		poll(RX_RELEASE_COMMAND_IDX);
		rd_chk(RX_PENDING_BYTES_IDX, 32'd104);
		check(32'(n_rptr), 32'h1);
		wr(RX_RELEASE_COMMAND_IDX, 32'h1);
		poll(RX_RELEASE_COMMAND_IDX);
		rd_chk(RX_PENDING_BYTES_IDX, 32'h0);
		wr(RX_RELEASE_COMMAND_IDX, 32'h1);
		rd_chk(RX_RELEASE_COMMAND_IDX, 32'h0);
		rd_chk(RX_PENDING_BYTES_IDX, 32'h0);
		complete_run();
	end
endmodule : hfq_top_tb
`default_nettype wire
